// *** shared/sram_core_pkg.sv ***
// Functional notes
// (R1) write starts when write port select is low at a positive clock rise; address latched
// (R2) first write word captured at the next positive rise into the lowest slot
// (R3) words captured on alternating edges until four held, then committed at the address
// (R4) a write request one cycle after a write start is ignored
// (R5) deselected write port finishes its burst, then ignores its inputs
// (R6) byte selects sampled with every word; deasserted byte leaves stored byte unchanged
// (R7) select 0 covers bits 8..0, select 1 bits 17..9; both high writes nothing
// (R8) reads of a just-written address return the newest data, forwarded if pending
// (R9) controller starts at most one transaction per positive rise
// (R10) both selects low after an idle cycle: read starts, write dropped
// (R11) both selects low after a read start: write wins
// (R12) both selects low after a write start: read wins
// (R13) both selects held low from idle alternate read and write, read first
// (R14) selects sampled on positive rises only; ports independent; pending bursts finish
// (R15) output impedance recalibrated every 1024 input clock cycles
// (R16) two free-running echo clocks follow the positive and negative input clocks
// (R17) read valid flag rises half a cycle before the first read word
// (R18) with the PLL enabled, lock follows 20 us of stable input clock
// (R19) input clocks stopped at least 30 ns reset the PLL, which then relocks
// (R20) PLL disabled: legacy mode with one-cycle read latency
// (R21) controller presents words A, A+1 in cycle t+1 and A+2, A+3 in t+2
// (R22) 2.5 latency read: A at negative rise of t+2, A+1, A+2 in t+3, A+3 at t+4
// (R23) powers up deselected; with both selects high outputs stay high impedance
// (R24) stopped clocks leave the device state unchanged; parking clocks high is preferred
// (R25) burst words go to the latched address and the next three locations, masked per word
package sram_core_pkg;
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = 2;
  localparam int BURST_LEN = 4;
  localparam int ADDR_W = 22;
  localparam int HIST_D = 4;
  localparam int REF_CLK_MHZ = 50;
  localparam int REF_PERIOD_NS = 1000 / REF_CLK_MHZ;
  localparam int LOCK_TIME_US = 20;
  localparam int LOCK_CY = LOCK_TIME_US * REF_CLK_MHZ;
  localparam int STOP_TIME_NS = 30;
  localparam int STOP_CY = (STOP_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int KGAP_CY = 8;
  localparam int RECAL_CY = 1024;
  localparam logic [1:0] SYNC_INIT = 2'h2;
endpackage

// *** shared/array_port_if.sv ***
`timescale 1ns/1ps
interface array_port_if #(
  parameter int AW = sram_core_pkg::ADDR_W
);
  logic we;
  logic [AW-1:0] waddr;
  logic [sram_core_pkg::BURST_LEN-1:0][sram_core_pkg::DATA_W-1:0] wdata;
  logic [sram_core_pkg::BURST_LEN-1:0][sram_core_pkg::NUM_BYTES-1:0] wen;
  logic [AW-1:0] raddr_p;
  logic [AW-1:0] raddr_n;
  logic [sram_core_pkg::DATA_W-1:0] rdata_p;
  logic [sram_core_pkg::DATA_W-1:0] rdata_n;
  modport ctrl (output we, waddr, wdata, wen, raddr_p, raddr_n, input rdata_p, rdata_n);
  modport mem (input we, waddr, wdata, wen, raddr_p, raddr_n, output rdata_p, rdata_n);
endinterface

// *** src/pin_sync3.sv ***
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // a change is taken only once the last two stages agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q_o <= INIT;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule

// *** src/burst_array.sv ***
`timescale 1ns/1ps
module burst_array #(
  parameter int AW = sram_core_pkg::ADDR_W
) (
  input wire logic k_clk_i,
  array_port_if.mem port
);
  localparam int BW = sram_core_pkg::BYTE_W;
  logic [sram_core_pkg::DATA_W-1:0] mem_q [2**AW];

  // whole burst lands in one edge; masked bytes keep their old value
  always_ff @(posedge k_clk_i) begin
    for (int j = 0; j < sram_core_pkg::BURST_LEN; j++) begin
      for (int b = 0; b < sram_core_pkg::NUM_BYTES; b++) begin
        if (port.we && port.wen[j][b]) begin
          mem_q[port.waddr + AW'(j)][b*BW +: BW] <= port.wdata[j][b*BW +: BW]; // [R25]
        end
      end
    end
  end

  assign port.rdata_p = mem_q[port.raddr_p];
  assign port.rdata_n = mem_q[port.raddr_n];
endmodule

// *** src/split_port_burst_sram_core.sv ***
`timescale 1ns/1ps
module split_port_burst_sram_core #(
  parameter int ADDR_W = sram_core_pkg::ADDR_W,
  parameter int KGAP_CY = sram_core_pkg::KGAP_CY
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic k_clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic read_port_select_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [sram_core_pkg::NUM_BYTES-1:0] byte_write_select_n_i,
  input wire logic [sram_core_pkg::DATA_W-1:0] wdata_i,
  input wire logic pll_disable_n_i,
  output logic [sram_core_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_oe_o,
  output logic read_valid_flag_o,
  output logic echo_clock_pos_o,
  output logic echo_clock_neg_o,
  output logic pll_locked_o,
  output logic imp_recal_o
);
  localparam int DW = sram_core_pkg::DATA_W;
  localparam int BW = sram_core_pkg::BYTE_W;
  localparam int NB = sram_core_pkg::NUM_BYTES;
  localparam int BL = sram_core_pkg::BURST_LEN;
  localparam int HD = sram_core_pkg::HIST_D;
  localparam int LOCK_CY = sram_core_pkg::LOCK_CY;
  localparam int LW = $clog2(LOCK_CY + 1);
  localparam int GAP_MAX = KGAP_CY + sram_core_pkg::STOP_CY;
  localparam int GW = $clog2(GAP_MAX + 1);
  localparam int RW = $clog2(sram_core_pkg::RECAL_CY);

  // ==========================================================
  // reference domain: pll lock model
  logic k_tog_q;
  logic [1:0] ref_pin;
  logic tog_seen_q;
  logic [GW-1:0] gap_q;
  logic [LW-1:0] lock_cnt_q;
  logic locked_q;
  logic pll_on;
  logic k_active;
  logic k_stopped;

  pin_sync3 #(
    .W(2),
    .INIT(sram_core_pkg::SYNC_INIT)
  ) u_ref_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({pll_disable_n_i, k_tog_q}),
    .q_o(ref_pin)
  );

  assign pll_on = ref_pin[1];
  assign k_active = ref_pin[0] != tog_seen_q;
  assign k_stopped = gap_q == GW'(GAP_MAX);

  // starts as stopped so that lock needs a full run of stable clock
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tog_seen_q <= 1'b0;
      gap_q <= GW'(GAP_MAX);
    end else begin
      tog_seen_q <= ref_pin[0];
      if (k_active) begin
        gap_q <= '0;
      end else if (!k_stopped) begin
        gap_q <= gap_q + GW'(1); // [R19]
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (!pll_on || k_stopped) begin
      lock_cnt_q <= '0; // [R19]
      locked_q <= 1'b0;
    end else if (!locked_q) begin
      lock_cnt_q <= lock_cnt_q + LW'(1);
      locked_q <= lock_cnt_q == LW'(LOCK_CY - 1); // [R18]
    end
  end

  assign pll_locked_o = locked_q;

  // ==========================================================
  // link domain: mode and readiness
  logic [1:0] k_ctl;
  logic legacy;
  logic ready;

  pin_sync3 #(
    .W(2),
    .INIT(sram_core_pkg::SYNC_INIT)
  ) u_k_sync (
    .clk_i(k_clk_i),
    .rst_i(rst_i),
    .d_i({pll_on, locked_q}),
    .q_o(k_ctl)
  );

  // limitation: mode is meant as a strap, changing it mid-burst garbles data
  assign legacy = ~k_ctl[1]; // [R20]
  assign ready = legacy | k_ctl[0]; // [R18]

  // ==========================================================
  // start arbitration and history
  logic rd_req;
  logic wr_req;
  logic rd_go;
  logic wr_go;
  logic [HD-1:0] rs_q;
  logic [HD-1:0] ws_q;
  logic [HD-1:0] rs_nx;
  logic [HD-1:0][ADDR_W-1:0] a_q;

  assign rd_req = ~read_port_select_n_i;
  assign wr_req = ~write_port_select_n_i;
  // a read started at the previous rise blocks a new read, so only the write can win after it
  assign rd_go = rd_req & ~rs_q[0] & ready; // [R10] [R12] [R13]
  assign wr_go = wr_req & ~ws_q[0] & ~rd_go & ready; // [R4] [R11] [R13]
  assign rs_nx = {rs_q[HD-2:0], rd_go};

  // history keeps shifting with selects high, so pending bursts finish
  always_ff @(posedge k_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs_q <= '0;
      ws_q <= '0;
      a_q <= '0;
    end else begin
      rs_q <= rs_nx; // [R14]
      ws_q <= {ws_q[HD-2:0], wr_go}; // [R1] [R5]
      a_q <= {a_q[HD-2:0], addr_i}; // [R1]
    end
  end

  // ==========================================================
  // write data capture on both edges
  logic [1:0][DW-1:0] wd_p_q;
  logic [1:0][DW-1:0] wd_n_q;
  logic [1:0][NB-1:0] be_p_q;
  logic [1:0][NB-1:0] be_n_q;
  logic [BL-1:0][DW-1:0] wr_data;
  logic [BL-1:0][NB-1:0] wr_en;

  always_ff @(posedge k_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_p_q <= '0;
      be_p_q <= '0;
    end else if (ws_q[0]) begin
      wd_p_q[0] <= wdata_i; // [R2] [R21]
      be_p_q[0] <= ~byte_write_select_n_i; // [R6] [R7]
    end else if (ws_q[1]) begin
      wd_p_q[1] <= wdata_i; // [R3]
      be_p_q[1] <= ~byte_write_select_n_i; // [R6]
    end
  end

  always_ff @(negedge k_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_n_q <= '0;
      be_n_q <= '0;
    end else if (ws_q[1]) begin
      wd_n_q[0] <= wdata_i; // [R3] [R21]
      be_n_q[0] <= ~byte_write_select_n_i; // [R6]
    end else if (ws_q[2]) begin
      wd_n_q[1] <= wdata_i; // [R3]
      be_n_q[1] <= ~byte_write_select_n_i; // [R6]
    end
  end

  assign wr_data = {wd_n_q[1], wd_p_q[1], wd_n_q[0], wd_p_q[0]};
  assign wr_en = {be_n_q[1], be_p_q[1], be_n_q[0], be_p_q[0]};

  // ==========================================================
  // array and commit
  array_port_if #(.AW(ADDR_W)) arr ();

  burst_array #(
    .AW(ADDR_W)
  ) u_array (
    .k_clk_i(k_clk_i),
    .port(arr)
  );

  // commit at the rise after the fourth word, while slot data still holds
  assign arr.we = ws_q[2]; // [R3]
  assign arr.waddr = a_q[2]; // [R25]
  assign arr.wdata = wr_data;
  assign arr.wen = wr_en; // [R7] [R25]

  // ==========================================================
  // read fetch with forwarding from an uncommitted burst
  function automatic logic [DW-1:0] fwd(input logic [ADDR_W-1:0] ra,
                                        input logic [DW-1:0] raw,
                                        input logic at_pos);
    logic [DW-1:0] w;
    logic [BL-1:0] cap;
    logic [ADDR_W-1:0] base;
    w = raw;
    cap = {ws_q[2] & at_pos, ws_q[2], ws_q[2] | (ws_q[1] & at_pos), ws_q[1] | ws_q[2]};
    base = ws_q[1] ? a_q[1] : a_q[2];
    for (int j = 0; j < BL; j++) begin
      for (int b = 0; b < NB; b++) begin
        if (cap[j] && wr_en[j][b] && ra == base + ADDR_W'(j)) begin
          w[b*BW +: BW] = wr_data[j][b*BW +: BW]; // [R8]
        end
      end
    end
    return w;
  endfunction

  // slot picks: history index and burst word for each edge and mode
  logic [1:0] p_i1;
  logic [1:0] p_i2;
  logic [1:0] p_w1;
  logic [1:0] p_w2;
  logic [1:0] n_i1;
  logic [1:0] n_i2;
  logic [1:0] n_w1;
  logic [1:0] n_w2;
  logic p_sel;
  logic n_sel;
  logic n_sel_nx;

  assign p_i1 = {~legacy, 1'b0}; // [R20] [R22]
  assign p_i2 = {~legacy, 1'b1};
  assign p_w1 = {1'b0, ~legacy};
  assign p_w2 = {1'b1, ~legacy};
  assign n_i1 = legacy ? 2'h1 : 2'h2; // [R20] [R22]
  assign n_i2 = legacy ? 2'h2 : 2'h3;
  assign n_w1 = {1'b0, legacy};
  assign n_w2 = {1'b1, legacy};

  assign p_sel = rs_q[p_i1] | rs_q[p_i2];
  assign n_sel = rs_q[n_i1] | rs_q[n_i2];
  assign n_sel_nx = rs_nx[n_i1] | rs_nx[n_i2];

  assign arr.raddr_p = rs_q[p_i1] ? a_q[p_i1] + ADDR_W'(p_w1) : a_q[p_i2] + ADDR_W'(p_w2);
  assign arr.raddr_n = rs_q[n_i1] ? a_q[n_i1] + ADDR_W'(n_w1) : a_q[n_i2] + ADDR_W'(n_w2);

  // ==========================================================
  // double-rate output registers
  logic [DW-1:0] q_p_q;
  logic [DW-1:0] q_n_q;
  logic oe_p_q;
  logic oe_n_q;
  logic vld_p_q;
  logic vld_n_q;

  always_ff @(posedge k_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_p_q <= '0;
      oe_p_q <= 1'b0;
      vld_p_q <= 1'b0;
    end else begin
      oe_p_q <= p_sel; // [R22] [R23]
      vld_p_q <= n_sel_nx; // [R17]
      if (p_sel) begin
        q_p_q <= fwd(arr.raddr_p, arr.rdata_p, 1'b1); // [R22]
      end
    end
  end

  always_ff @(negedge k_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_n_q <= '0;
      oe_n_q <= 1'b0;
      vld_n_q <= 1'b0;
    end else begin
      oe_n_q <= n_sel; // [R22] [R23]
      vld_n_q <= p_sel; // [R17]
      if (n_sel) begin
        q_n_q <= fwd(arr.raddr_n, arr.rdata_n, 1'b0); // [R22]
      end
    end
  end

  // clock-level mux stands for the output cell; a parked clock holds the last half
  assign rdata_o = k_clk_i ? q_p_q : q_n_q; // [R24]
  assign rdata_oe_o = k_clk_i ? oe_p_q : oe_n_q; // [R23]
  assign read_valid_flag_o = k_clk_i ? vld_p_q : vld_n_q; // [R17]
  assign echo_clock_pos_o = k_clk_i; // [R16]
  assign echo_clock_neg_o = ~k_clk_i; // [R16]

  // ==========================================================
  // impedance recalibration tick and link activity toggle
  logic [RW-1:0] rc_q;
  logic imp_q;

  always_ff @(posedge k_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_q <= '0;
      imp_q <= 1'b0;
      k_tog_q <= 1'b0;
    end else begin
      rc_q <= rc_q + RW'(1); // [R15]
      imp_q <= rc_q == RW'(sram_core_pkg::RECAL_CY - 1); // [R15]
      k_tog_q <= ~k_tog_q;
    end
  end

  assign imp_recal_o = imp_q;

  // ==========================================================
  // checks
  chk_rd_idle_first: assert property ( // [R10]
    @(posedge k_clk_i) disable iff (rst_i)
    (rd_req && wr_req && ready && !rs_q[0] && !ws_q[0]) |=> (rs_q[0] && !ws_q[0]))
    else $error("read did not win from idle");

  chk_wr_after_rd: assert property ( // [R11]
    @(posedge k_clk_i) disable iff (rst_i)
    (rd_req && wr_req && ready && rs_q[0]) |=> (ws_q[0] && !rs_q[0]))
    else $error("write did not win after read");

  chk_rd_after_wr: assert property ( // [R12]
    @(posedge k_clk_i) disable iff (rst_i)
    (rd_req && wr_req && ready && ws_q[0]) |=> (rs_q[0] && !ws_q[0]))
    else $error("read did not win after write");

  chk_wr_spacing: assert property ( // [R4]
    @(posedge k_clk_i) disable iff (rst_i)
    ws_q[0] |=> !ws_q[0])
    else $error("writes started back to back");

  chk_commit_delay: assert property ( // [R3]
    @(posedge k_clk_i) disable iff (rst_i)
    ws_q[0] |-> ##2 (arr.we && arr.waddr == $past(a_q[0], 2)))
    else $error("burst commit late or at wrong address");

  chk_read_slots: assert property ( // [R22]
    @(posedge k_clk_i) disable iff (rst_i)
    (rs_q[0] && !legacy) |-> ##2 oe_n_q ##1 (oe_p_q && oe_n_q) ##1 oe_p_q)
    else $error("read words not on the 2.5 cycle slots");

  chk_valid_lead: assert property ( // [R17]
    @(posedge k_clk_i) disable iff (rst_i)
    vld_p_q |-> oe_n_q)
    else $error("valid flag without following word");

  chk_idle_hiz: assert property ( // [R23]
    @(posedge k_clk_i) disable iff (rst_i)
    (rs_q == '0) |=> !oe_p_q)
    else $error("outputs driven with no read pending");

  chk_recal_period: assert property ( // [R15]
    @(posedge k_clk_i) disable iff (rst_i)
    imp_q |-> (rc_q == RW'(0)) ##1 !imp_q [*8])
    else $error("recalibration tick off period");

  chk_lock_time: assert property ( // [R18]
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(locked_q) |-> lock_cnt_q == LW'(LOCK_CY))
    else $error("pll locked before its lock time");

  chk_stop_unlock: assert property ( // [R19]
    @(posedge ref_clk_i) disable iff (rst_i)
    k_stopped |=> !locked_q)
    else $error("pll kept lock with clock stopped");

  cov_alternate: cover property (
    @(posedge k_clk_i) disable iff (rst_i)
    rs_q[0] ##1 ws_q[0] ##1 rs_q[0] ##1 ws_q[0]);

  cov_fwd_read: cover property (
    @(posedge k_clk_i) disable iff (rst_i)
    ws_q[0] ##1 rs_q[0] && a_q[0] == a_q[1]);

  cov_lock: cover property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(locked_q));
endmodule

// *** sim/host_ctrl_model.sv ***
`timescale 1ns/1ps
// ==========
// host controller model
module host_ctrl_model #(
  parameter int ADDR_W = 8
) (
  input wire logic k_run_i,
  input wire logic [17:0] rdata_i,
  input wire logic rdata_oe_i,
  input wire logic read_valid_flag_i,
  output logic k_clk_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic read_port_select_n_o,
  output logic write_port_select_n_o,
  output logic [1:0] byte_write_select_n_o,
  output logic [17:0] wdata_o
);
  initial begin
    k_clk_o = 1'b0;
    addr_o = '0;
    read_port_select_n_o = 1'b1;
    write_port_select_n_o = 1'b1;
    byte_write_select_n_o = 2'h3;
    wdata_o = 18'h0;
    #7;
    forever begin
      #80;
      if (k_run_i) begin
        k_clk_o = ~k_clk_o;
      end else begin
        // parked high, the level the document prefers for stopped clocks
        k_clk_o = 1'b1;
      end
    end
  end

  // one start per rise; selects and address let go just after the sampling rise
  task automatic issue(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] a);
    @(negedge k_clk_o);
    #20;
    read_port_select_n_o = rd_n;
    write_port_select_n_o = wr_n;
    addr_o = a;
    @(posedge k_clk_o);
    #20;
    read_port_select_n_o = 1'b1;
    write_port_select_n_o = 1'b1;
    addr_o = ~a;
  endtask

  // called right after issue: words for rise t+1, fall t+1, rise t+2, fall t+2
  task automatic wr_data(input logic [3:0][17:0] d, input logic [3:0][1:0] b);
    wdata_o = d[0];
    byte_write_select_n_o = b[0];
    for (int i = 1; i < 4; i++) begin
      if (i == 2) begin
        @(negedge k_clk_o);
      end else begin
        @(posedge k_clk_o);
      end
      #20;
      wdata_o = d[i];
      byte_write_select_n_o = b[i];
    end
    @(negedge k_clk_o);
    #20;
    // released lines show the inverse, never a stale copy
    wdata_o = ~d[3];
    byte_write_select_n_o = ~b[3];
  endtask

  // called right after issue; each half cycle sampled 40 ns after its edge
  task automatic rd_get(output logic [3:0][17:0] q, output logic v_pre, output logic v_lead,
                        output logic oe_end);
    @(posedge k_clk_o);
    @(negedge k_clk_o);
    #40;
    v_pre = read_valid_flag_i;
    @(posedge k_clk_o);
    #40;
    v_lead = read_valid_flag_i;
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || i == 2) begin
        @(negedge k_clk_o);
      end else begin
        @(posedge k_clk_o);
      end
      #40;
      q[i] = rdata_i;
    end
    @(negedge k_clk_o);
    #40;
    oe_end = rdata_oe_i;
  endtask
endmodule

// *** sim/test_split_port_burst_sram_core.sv ***
`timescale 1ns/1ps
module test_split_port_burst_sram_core;
  typedef struct packed {
    logic [7:0] addr;
    logic [17:0] base;
    logic [7:0] masks;
  } row_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic k_run = 1'b1;
  logic pll_disable_n = 1'b1;
  logic k_clk;
  logic [7:0] addr;
  logic rps_n;
  logic wps_n;
  logic [1:0] bws_n;
  logic [17:0] wdata;
  logic [17:0] rdata;
  logic oe;
  logic valid;
  logic ecp;
  logic ecn;
  logic locked;
  logic recal;
  int err_total = 0;
  int compares = 0;
  int kcnt = 0;
  int gap = 0;
  int pulses = 0;
  logic [17:0] mem [256];
  row_t rows [5] = '{'{8'h10, 18'h00000, 8'h00}, '{8'h20, 18'h11111, 8'h00},
                     '{8'hfe, 18'h22222, 8'h00}, '{8'h10, 18'h3c3c3, 8'he4},
                     '{8'hfe, 18'h0f0f0, 8'h1b}};

  // ==========
  // clock, design and far side
  always #10 ref_clk_i = ~ref_clk_i;

  split_port_burst_sram_core #(.ADDR_W(8)) uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .k_clk_i(k_clk), .addr_i(addr),
    .read_port_select_n_i(rps_n), .write_port_select_n_i(wps_n),
    .byte_write_select_n_i(bws_n), .wdata_i(wdata), .pll_disable_n_i(pll_disable_n),
    .rdata_o(rdata), .rdata_oe_o(oe), .read_valid_flag_o(valid), .echo_clock_pos_o(ecp),
    .echo_clock_neg_o(ecn), .pll_locked_o(locked), .imp_recal_o(recal));

  host_ctrl_model #(.ADDR_W(8)) p (
    .k_run_i(k_run), .rdata_i(rdata), .rdata_oe_i(oe), .read_valid_flag_i(valid),
    .k_clk_o(k_clk), .addr_o(addr), .read_port_select_n_o(rps_n),
    .write_port_select_n_o(wps_n), .byte_write_select_n_o(bws_n), .wdata_o(wdata));

  // counted at the fall, where the tick has settled
  always @(negedge k_clk) begin
    kcnt++;
    if (recal === 1'b1) begin
      gap = kcnt;
      kcnt = 0;
      pulses++;
    end
  end

  // ==========
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr_row(input logic [7:0] a, input logic [17:0] base, input logic [7:0] m,
                        input logic rn);
    logic [3:0][17:0] d;
    logic [3:0][1:0] b;
    logic [7:0] x;
    for (int i = 0; i < 4; i++) begin
      d[i] = base + 18'(i) * 18'h01111;
      b[i] = m[2*i +: 2];
      x = a + 8'(i);
      if (!b[i][0]) mem[x][8:0] = d[i][8:0];
      if (!b[i][1]) mem[x][17:9] = d[i][17:9];
    end
    p.issue(rn, 1'b0, a);
    p.wr_data(d, b);
  endtask

  task automatic rd_row(input logic [7:0] a, input logic wn, input logic solo);
    logic [3:0][17:0] q;
    logic vp;
    logic vl;
    logic oe_end;
    p.issue(1'b0, wn, a);
    p.rd_get(q, vp, vl, oe_end);
    for (int i = 0; i < 4; i++) chk(q[i], mem[a + 8'(i)]);
    chk(vl, 1'b1);
    if (solo) begin
      chk(vp, 1'b0);
      chk(oe_end, 1'b0);
    end
  endtask

  task automatic wait_lock();
    for (int n = 0; n < 400 && locked !== 1'b1; n++) @(negedge ref_clk_i);
    chk(locked, 1'b1);
    repeat (8) @(posedge k_clk);
  endtask

  // ==========
  // sequence
  initial begin
    repeat (6) @(negedge ref_clk_i);
    chk(oe, 1'b0);
    chk(valid, 1'b0);
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (900) @(negedge ref_clk_i);
    chk(locked, 1'b0);
    wait_lock();
    chk(oe, 1'b0);
    repeat (4) begin
      @(negedge ref_clk_i);
      chk(ecp, k_clk);
      chk(ecn, !k_clk);
    end
    foreach (rows[n]) begin
      wr_row(rows[n].addr, rows[n].base, rows[n].masks, 1'b1);
      rd_row(rows[n].addr, 1'b1, 1'b1);
    end
    // a second write one rise later must be ignored
    @(posedge k_clk);
    fork
      wr_row(8'h10, 18'h15a5a, 8'h00, 1'b1);
      begin
        @(posedge k_clk);
        p.issue(1'b1, 1'b0, 8'h20);
      end
    join
    rd_row(8'h20, 1'b1, 1'b1);
    rd_row(8'h10, 1'b1, 1'b1);
    @(posedge k_clk);
    fork
      wr_row(8'h30, 18'h0abcd, 8'h00, 1'b1);
      begin
        @(posedge k_clk);
        rd_row(8'h30, 1'b1, 1'b1);
      end
    join
    // both selects low on three rises from idle: read, write, read
    @(posedge k_clk);
    fork
      rd_row(8'h20, 1'b0, 1'b0);
      begin
        @(posedge k_clk);
        wr_row(8'h40, 18'h2a5a5, 8'h00, 1'b0);
      end
      begin
        repeat (2) @(posedge k_clk);
        rd_row(8'h40, 1'b0, 1'b0);
      end
    join
    rd_row(8'h20, 1'b1, 1'b1);
    @(negedge ref_clk_i);
    k_run = 1'b0;
    repeat (50) @(negedge ref_clk_i);
    chk(locked, 1'b0);
    k_run = 1'b1;
    repeat (900) @(negedge ref_clk_i);
    chk(locked, 1'b0);
    wait_lock();
    rd_row(8'h40, 1'b1, 1'b1);
    pulses = 0;
    for (int n = 0; n < 2200 && pulses < 2; n++) @(posedge k_clk);
    chk(gap, 1024);
    @(negedge ref_clk_i);
    pll_disable_n = 1'b0;
    repeat (10) @(posedge k_clk);
    p.issue(1'b0, 1'b1, 8'h40);
    @(negedge k_clk);
    #40;
    chk(valid, 1'b1);
    @(posedge k_clk);
    #40;
    chk(rdata, mem[8'h40]);
    @(negedge k_clk);
    #40;
    chk(rdata, mem[8'h41]);
    // legacy read one rise after a write must see the captured words
    @(posedge k_clk);
    fork
      wr_row(8'h50, 18'h1e1e1, 8'h00, 1'b1);
      begin
        @(posedge k_clk);
        p.issue(1'b0, 1'b1, 8'h50);
        @(posedge k_clk);
        #40;
        chk(rdata, mem[8'h50]);
        @(negedge k_clk);
        #40;
        chk(rdata, mem[8'h51]);
      end
    join
    print_verdict();
  end

  initial begin
    // the recalibration wait dominates, ending the run near 330 us; allow over twice that
    #800000;
    err_total++;
    print_verdict();
  end
endmodule
